// ---- rtl/frame_pkg.sv ----
// Purpose: Constants and types for the serial frame builder.
// Assumes: One 100 MHz clock, synchronous active-low reset.
// Notes: Referenced by the checksum and frame builder files through scoped names only.
//
// Functional notes
// - Frame opens with 0x7E, then two length bytes MSB first, counting type through payload.
// - Last byte is 0xFF minus the low eight bits of the sum from offset 3.
// - Arriving network data produces a receive frame with type byte 0x80.
// - Eight-byte source field: four zero bytes, then sender IP, MSB first.
// - Offset 12 of receive frame holds link margin above sensitivity.
// - Received payload from offset 14, at most 1392 bytes, then checksum.
// - Each command answer goes out as a response frame with type 0x88.
// - Several response frames may answer one request; host accepts them all.
// - Offsets 5 and 6 carry the two command name characters, first first.
// - Status byte follows: 0 ok, 1 error, 2 unknown command, 3 bad parameter.
// - Answer to a write carries no value bytes; status is followed by checksum.
// - Answer to a read appends the raw value bytes before the checksum.
package frame_pkg;

  // ==========================================================================
  // Envelope and frame types
  localparam logic [7:0] START_BYTE = 8'h7e;
  localparam logic [7:0] TYPE_RX = 8'h80;
  localparam logic [7:0] TYPE_RSP = 8'h88;
  localparam logic [7:0] CSUM_BASE = 8'hff;
  localparam int OFS_TYPE = 3;
  localparam int OFS_MARGIN = 12;
  localparam int OFS_OPTIONS = 13;
  localparam int OFS_PAYLOAD = 14;
  localparam logic [7:0] OPTIONS_NONE = 8'h00;

  // ==========================================================================
  // Body sizes, counted after the type byte
  localparam logic [3:0] RX_BODY_LEN = 4'ha;
  localparam logic [3:0] RSP_BODY_LEN = 4'h4;
  localparam logic [10:0] MAX_PAYLOAD = 11'h570; // 1392 bytes
  localparam logic [15:0] RX_FIXED_LEN = 16'h000b; // Type plus body
  localparam logic [15:0] RSP_FIXED_LEN = 16'h0005;

  // ==========================================================================
  // Status codes of a command answer
  localparam logic [7:0] STATUS_OK = 8'h00;
  localparam logic [7:0] STATUS_ERROR = 8'h01;
  localparam logic [7:0] STATUS_BAD_CMD = 8'h02;
  localparam logic [7:0] STATUS_BAD_PARAM = 8'h03;

  // ==========================================================================
  // Buffering and reset values
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 8;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // Byte class for which bytes enter the checksum; the builder tracks this with in_sum
  typedef enum logic [1:0] {
    KIND_ENV = 2'b00,
    KIND_SUM = 2'b01,
    KIND_CSUM = 2'b10
  } byte_kind_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_LEN_HI = 3'b010,
    ST_LEN_LO = 3'b011,
    ST_TYPE = 3'b100,
    ST_BODY = 3'b101,
    ST_PAYLOAD = 3'b110,
    ST_CSUM = 3'b111
  } frame_state_t;

endpackage

// ---- rtl/byte_stream_if.sv ----
// Purpose: Valid/ready byte stream between the buffer and the framer.
// Assumes: Single clock domain.
// Notes: A byte moves on a cycle with valid and ready both high.
`timescale 1ns/1ps
interface byte_stream_if;
  logic valid;
  logic ready;
  logic [7:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ---- rtl/byte_fifo.sv ----
// Purpose: Small payload buffer between the data source and the framer.
// Assumes: Synchronous active-low reset, one clock.
// Notes: Full and empty are flops so the ready seen outside is registered.
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic i_valid,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_ready,
  // Drain side
  byte_stream_if.src out
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_q, rd_ptr_q;
  logic [AW:0] count_q, count_d;
  logic ready_q, empty_q;
  logic push, pop;

  // ==========================================================================
  // Handshakes and occupancy
  assign push = i_valid && ready_q;
  assign pop = out.ready && !empty_q;
  assign o_ready = ready_q; // Straight from a flop
  assign out.valid = !empty_q;
  assign out.data = mem[rd_ptr_q];

  always_comb begin
    count_d = count_q;
    if (push && !pop) begin
      count_d = count_q + 1'b1;
    end else if (pop && !push) begin
      count_d = count_q - 1'b1;
    end
  end

  // Pointers and flags; flags load from the next count, so they cost no cycle of ready after a pop
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
      ready_q <= 1'b0;
      empty_q <= 1'b1;
    end else begin
      if (push) wr_ptr_q <= wr_ptr_q + 1'b1;
      if (pop) rd_ptr_q <= rd_ptr_q + 1'b1;
      count_q <= count_d;
      ready_q <= (count_d != (AW+1)'(DEPTH));
      empty_q <= (count_d == '0);
    end
  end

  // Storage has no reset; only written slots are ever read
  always_ff @(posedge clk) begin
    if (push) mem[wr_ptr_q] <= i_data;
  end
endmodule

// ---- rtl/frame_checksum.sv ----
// Purpose: Running eight-bit sum of the bytes that a frame checksums.
// Assumes: Clear and add are never high together.
// Notes: Result is valid the cycle after the last add.
`timescale 1ns/1ps
module frame_checksum (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control and data
  input wire logic i_clear,
  input wire logic i_add,
  input wire logic [7:0] i_byte,
  // Result
  output logic [7:0] o_csum
);
  logic [7:0] sum_q;

  // Carry out is dropped on purpose: only the low eight bits count
  always_ff @(posedge clk) begin
    if (!rst_n || i_clear) begin
      sum_q <= 8'h00;
    end else if (i_add) begin
      sum_q <= sum_q + i_byte;
    end
  end

  assign o_csum = frame_pkg::CSUM_BASE - sum_q;
endmodule

// ---- rtl/api_frame_builder.sv ----
// Purpose: Builds receive and command-response frames for the serial host link.
// Assumes: Requests and payload come from logic on the same clock.
// Notes: One frame at a time; payload bytes are taken from an 8-byte buffer.
`timescale 1ns/1ps
module api_frame_builder (
  // Clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_RST_N,
  // Receive event
  input wire logic I_RX_REQ,
  input wire logic [31:0] I_RX_SRC_IP,
  input wire logic [7:0] I_RX_MARGIN,
  input wire logic [10:0] I_RX_LEN,
  // Command answer event
  input wire logic I_RSP_REQ,
  input wire logic [7:0] I_RSP_TAG,
  input wire logic [15:0] I_RSP_CMD,
  input wire logic [7:0] I_RSP_STATUS,
  input wire logic [10:0] I_RSP_LEN,
  output logic O_REQ_READY,
  // Payload bytes
  input wire logic I_PL_VALID,
  input wire logic [7:0] I_PL_DATA,
  output logic O_PL_READY,
  // Serial byte stream toward the host
  output logic O_TX_VALID,
  output logic [7:0] O_TX_DATA,
  input wire logic I_TX_READY
);

  // ==========================================================================
  // Frame control state
  frame_pkg::frame_state_t state_q, state_d;
  logic is_rsp_q;
  logic req_ready_q;
  logic accept;
  logic take_rx;
  logic emit;
  logic slot_free;
  logic last_body;
  logic sum_add;
  logic [3:0] body_idx_q;
  logic [10:0] pl_left_q;
  logic [10:0] req_len;
  logic [10:0] pl_len_clamped;
  logic [15:0] fixed_len;
  logic [15:0] frame_len_q;

  // Request fields held for the whole frame
  logic [31:0] src_ip_q;
  logic [7:0] margin_q;
  logic [7:0] tag_q;
  logic [15:0] cmd_q;
  logic [7:0] status_q;
  logic [7:0] ip_byte [4];

  // Byte selection and the output register
  logic [7:0] rx_field;
  logic [7:0] rsp_field;
  logic [7:0] next_byte;
  logic tx_valid_q;
  logic [7:0] tx_data_q;

  // Payload buffer and checksum
  logic pl_ready;
  logic [7:0] csum;
  byte_stream_if pl_stream ();

  // ==========================================================================
  // Decode helpers

  // Type, body and payload bytes enter the checksum; the envelope does not
  function automatic logic in_sum(input frame_pkg::frame_state_t st);
    return (st == frame_pkg::ST_TYPE) || (st == frame_pkg::ST_BODY) || (st == frame_pkg::ST_PAYLOAD);
  endfunction

  // True on the last body byte of the frame kind in flight
  function automatic logic body_last(input logic rsp, input logic [3:0] idx);
    return (idx + 4'h1) == (rsp ? frame_pkg::RSP_BODY_LEN : frame_pkg::RX_BODY_LEN);
  endfunction

  // ==========================================================================
  // Payload buffer

  // Eight bytes of slack let the source run ahead of the header bytes
  byte_fifo #(
    .WIDTH(frame_pkg::FIFO_WIDTH),
    .DEPTH(frame_pkg::FIFO_DEPTH)
  ) byte_fifo_i (
    .clk(I_SYS_CLK),
    .rst_n(I_RST_N),
    .i_valid(I_PL_VALID),
    .i_data(I_PL_DATA),
    .o_ready(pl_ready),
    .out(pl_stream.src)
  );

  // The buffer's ready is already a flop
  assign O_PL_READY = pl_ready;

  // Pull a byte only when it can go straight into the output register
  assign pl_stream.ready = slot_free && (state_q == frame_pkg::ST_PAYLOAD);

  // ==========================================================================
  // Checksum

  // Cleared on the accepting edge, before the first summed byte exists
  frame_checksum frame_checksum_i (
    .clk(I_SYS_CLK),
    .rst_n(I_RST_N),
    .i_clear(accept),
    .i_add(sum_add),
    .i_byte(next_byte),
    .o_csum(csum)
  );

  // Summed as each byte is loaded, so the result is ready one cycle later
  assign sum_add = emit && in_sum(state_q);

  // ==========================================================================
  // Request intake

  // A receive event wins if both kinds are raised together
  assign accept = req_ready_q && (I_RX_REQ || I_RSP_REQ);
  assign take_rx = I_RX_REQ;
  assign req_len = take_rx ? I_RX_LEN : I_RSP_LEN;

  // Clamp keeps an oversized request inside the payload limit
  assign pl_len_clamped = (req_len > frame_pkg::MAX_PAYLOAD) ? frame_pkg::MAX_PAYLOAD : req_len;
  assign fixed_len = take_rx ? frame_pkg::RX_FIXED_LEN : frame_pkg::RSP_FIXED_LEN;

  // Ready in idle only; answers may follow back to back for one command
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      req_ready_q <= 1'b0;
    end else begin
      req_ready_q <= (state_d == frame_pkg::ST_IDLE);
    end
  end

  // Frame kind and fields, frozen until the checksum is out
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      is_rsp_q <= 1'b0;
      src_ip_q <= '0;
      margin_q <= frame_pkg::RESET_BYTE;
      tag_q <= frame_pkg::RESET_BYTE;
      cmd_q <= '0;
      status_q <= frame_pkg::RESET_BYTE;
    end else if (accept) begin
      is_rsp_q <= !take_rx;
      src_ip_q <= I_RX_SRC_IP;
      margin_q <= I_RX_MARGIN;
      tag_q <= I_RSP_TAG;
      cmd_q <= I_RSP_CMD;
      status_q <= I_RSP_STATUS;
    end
  end

  // Length counts type, body and payload, never the checksum
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      frame_len_q <= '0;
    end else if (accept) begin
      frame_len_q <= fixed_len + {5'h00, pl_len_clamped};
    end
  end

  // Body position; restarts with every accepted request
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      body_idx_q <= '0;
    end else if (accept) begin
      body_idx_q <= '0;
    end else if (emit && state_q == frame_pkg::ST_BODY) begin
      body_idx_q <= body_idx_q + 4'h1;
    end
  end

  // Payload bytes still owed; zero means no payload, as in a write answer or an empty receive frame
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      pl_left_q <= '0;
    end else if (accept) begin
      pl_left_q <= pl_len_clamped;
    end else if (emit && state_q == frame_pkg::ST_PAYLOAD) begin
      pl_left_q <= pl_left_q - 11'h001;
    end
  end

  // ==========================================================================
  // Frame sequencing

  // A byte may load when the output register is empty or being drained
  assign slot_free = !tx_valid_q || I_TX_READY;
  assign last_body = body_last(is_rsp_q, body_idx_q);

  // Payload waits on the buffer; every other state has its byte at hand
  assign emit = slot_free && (state_q != frame_pkg::ST_IDLE) &&
    ((state_q != frame_pkg::ST_PAYLOAD) || pl_stream.valid);

  // Next state; each step advances only when its byte was loaded
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      frame_pkg::ST_IDLE: begin
        if (accept) state_d = frame_pkg::ST_START;
      end
      frame_pkg::ST_START: begin
        if (emit) state_d = frame_pkg::ST_LEN_HI;
      end
      frame_pkg::ST_LEN_HI: begin
        if (emit) state_d = frame_pkg::ST_LEN_LO;
      end
      frame_pkg::ST_LEN_LO: begin
        if (emit) state_d = frame_pkg::ST_TYPE;
      end
      frame_pkg::ST_TYPE: begin
        if (emit) state_d = frame_pkg::ST_BODY;
      end
      frame_pkg::ST_BODY: begin
        if (emit && last_body) begin
          state_d = (pl_left_q == '0) ? frame_pkg::ST_CSUM : frame_pkg::ST_PAYLOAD;
        end
      end
      frame_pkg::ST_PAYLOAD: begin
        if (emit && pl_left_q == 11'h001) state_d = frame_pkg::ST_CSUM;
      end
      frame_pkg::ST_CSUM: begin
        if (emit) state_d = frame_pkg::ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      state_q <= frame_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================================
  // Byte selection

  // Sender address bytes, most significant first
  for (genvar g = 0; g < 4; g++) begin : g_ip_bytes
    assign ip_byte[g] = src_ip_q[31 - 8 * g -: 8];
  end

  // Receive body: zero pad, address, margin, options
  always_comb begin
    rx_field = frame_pkg::RESET_BYTE;
    unique case (body_idx_q)
      4'h0, 4'h1, 4'h2, 4'h3: rx_field = 8'h00;
      4'h4, 4'h5, 4'h6, 4'h7: rx_field = ip_byte[body_idx_q[1:0]];
      4'h8: rx_field = margin_q;
      4'h9: rx_field = frame_pkg::OPTIONS_NONE;
      default: rx_field = frame_pkg::RESET_BYTE;
    endcase
  end

  // Answer body: tag, two name characters, status
  always_comb begin
    rsp_field = frame_pkg::RESET_BYTE;
    unique case (body_idx_q)
      4'h0: rsp_field = tag_q;
      4'h1: rsp_field = cmd_q[15:8];
      4'h2: rsp_field = cmd_q[7:0];
      4'h3: rsp_field = status_q;
      default: rsp_field = frame_pkg::RESET_BYTE;
    endcase
  end

  // Byte offered to the output register in each state
  always_comb begin
    next_byte = frame_pkg::RESET_BYTE;
    unique case (state_q)
      frame_pkg::ST_IDLE: next_byte = frame_pkg::RESET_BYTE;
      frame_pkg::ST_START: next_byte = frame_pkg::START_BYTE;
      frame_pkg::ST_LEN_HI: next_byte = frame_len_q[15:8];
      frame_pkg::ST_LEN_LO: next_byte = frame_len_q[7:0];
      frame_pkg::ST_TYPE: next_byte = is_rsp_q ? frame_pkg::TYPE_RSP : frame_pkg::TYPE_RX;
      frame_pkg::ST_BODY: next_byte = is_rsp_q ? rsp_field : rx_field;
      frame_pkg::ST_PAYLOAD: next_byte = pl_stream.data;
      frame_pkg::ST_CSUM: next_byte = csum;
    endcase
  end

  // ==========================================================================
  // Output register

  // One byte deep; loading while the host drains keeps full rate
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      tx_valid_q <= 1'b0;
      tx_data_q <= frame_pkg::RESET_BYTE;
    end else if (emit) begin
      tx_valid_q <= 1'b1;
      tx_data_q <= next_byte;
    end else if (I_TX_READY) begin
      tx_valid_q <= 1'b0;
    end
  end

  // Top outputs straight from flops
  assign O_TX_VALID = tx_valid_q;
  assign O_TX_DATA = tx_data_q;
  assign O_REQ_READY = req_ready_q;

  // ==========================================================================
  // Assertions

  property p_start_byte;
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
    (emit && state_q == frame_pkg::ST_START) |=> (O_TX_VALID && O_TX_DATA == frame_pkg::START_BYTE);
  endproperty
  a_start_byte: assert property (p_start_byte)
    else $error("frame did not open with the start byte");

  property p_type_rx;
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
    (emit && state_q == frame_pkg::ST_TYPE && !is_rsp_q) |=> (O_TX_DATA == frame_pkg::TYPE_RX);
  endproperty
  a_type_rx: assert property (p_type_rx)
    else $error("receive frame carries a wrong type byte");

  property p_type_rsp;
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
    (emit && state_q == frame_pkg::ST_TYPE && is_rsp_q) |=> (O_TX_DATA == frame_pkg::TYPE_RSP);
  endproperty
  a_type_rsp: assert property (p_type_rsp)
    else $error("answer frame carries a wrong type byte");

  property p_options_zero;
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
    (emit && state_q == frame_pkg::ST_BODY && !is_rsp_q && body_last(1'b0, body_idx_q)) |=> (O_TX_DATA == 8'h00);
  endproperty
  a_options_zero: assert property (p_options_zero)
    else $error("options byte of a receive frame is not zero");

  property p_tx_hold;
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
    (O_TX_VALID && !I_TX_READY) |=> (O_TX_VALID && $stable(O_TX_DATA));
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("offered byte changed before the host took it");

  property p_ready_idle;
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
    O_REQ_READY |-> (state_q == frame_pkg::ST_IDLE);
  endproperty
  a_ready_idle: assert property (p_ready_idle)
    else $error("request ready raised while a frame is in flight");

  property p_write_ends;
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
    (emit && state_q == frame_pkg::ST_BODY && last_body && pl_left_q == '0) |=> (state_q == frame_pkg::ST_CSUM);
  endproperty
  a_write_ends: assert property (p_write_ends)
    else $error("status of a write answer not followed by the checksum");

  property p_csum_byte;
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
    (emit && state_q == frame_pkg::ST_CSUM) |=> (O_TX_DATA == $past(csum));
  endproperty
  a_csum_byte: assert property (p_csum_byte)
    else $error("closing byte is not the running checksum");

  // Main scenarios worth seeing
  c_rx_frame: cover property (@(posedge I_SYS_CLK) disable iff (!I_RST_N) accept && I_RX_REQ);
  c_rsp_read: cover property (@(posedge I_SYS_CLK) disable iff (!I_RST_N) accept && !I_RX_REQ && I_RSP_LEN != '0);
  c_host_stall: cover property (@(posedge I_SYS_CLK) disable iff (!I_RST_N) O_TX_VALID && !I_TX_READY);
  c_pl_starved: cover property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    state_q == frame_pkg::ST_PAYLOAD && !pl_stream.valid);
endmodule

// ---- bench/host_model.sv ----
// Purpose: Host end of the serial link, taking frame bytes
// Assumes: A byte moves when valid and ready are both high
// Notes: Stalls one cycle in three to exercise backpressure
`timescale 1ns/1ps
module host_model (
  // Link
  input wire logic i_clk,
  input wire logic i_valid,
  input wire logic [7:0] i_data,
  output logic o_ready
);
  logic [7:0] q[$];
  int cnt = 0;
  // ==========================================
  // Capture; any number of frames per request
  always @(posedge i_clk) begin
    if (i_valid && o_ready) q.push_back(i_data); // Bench checks the checksum
  end
  // Ready moves on the falling edge, away from the sampling edge
  always @(negedge i_clk) begin
    cnt <= cnt + 1;
    o_ready <= (cnt % 3) != 2;
  end
endmodule

// ---- bench/api_frame_builder_tb.sv ----
// Purpose: Self-checking bench for the frame builder
// Assumes: Request is taken on an edge with ready high
// Notes: Payload is queued before the request
`timescale 1ns/1ps
module api_frame_builder_tb;
  logic clk = 0, rst_n = 0, rx_req = 0, rsp_req = 0, pl_valid = 0;
  logic [31:0] ip = '0;
  logic [7:0] mg = 0, tag = 0, st = 0, pl_data = 0, tx_data;
  logic [15:0] cmd = 0;
  logic [10:0] pl_len = 0;
  logic req_ready, pl_ready, tx_valid, tx_ready;
  logic [7:0] pq[$], ex[$];
  int mismatches = 0, n_tests = 0;
  always #5 clk = ~clk;
  api_frame_builder api_frame_builder_i (.I_SYS_CLK(clk), .I_RST_N(rst_n), .I_RX_REQ(rx_req),
    .I_RX_SRC_IP(ip), .I_RX_MARGIN(mg), .I_RX_LEN(pl_len), .I_RSP_REQ(rsp_req), .I_RSP_TAG(tag),
    .I_RSP_CMD(cmd), .I_RSP_STATUS(st), .I_RSP_LEN(pl_len), .O_REQ_READY(req_ready),
    .I_PL_VALID(pl_valid), .I_PL_DATA(pl_data), .O_PL_READY(pl_ready), .O_TX_VALID(tx_valid),
    .O_TX_DATA(tx_data), .I_TX_READY(tx_ready));
  host_model host_model_i (.i_clk(clk), .i_valid(tx_valid), .i_data(tx_data), .o_ready(tx_ready));
  // ==========================================
  // Payload feeder; idle data toggles so stale bytes never match
  always @(posedge clk) if (pl_valid && pl_ready) void'(pq.pop_front());
  always @(negedge clk) begin
    pl_valid <= pq.size() > 0;
    pl_data <= pq.size() > 0 ? pq[0] : ~pl_data;
  end
  task check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Build the expected frame, request it, compare what the host saw
  task run(input bit rsp, input int n);
    logic [7:0] sum;
    int i, len;
    if (rsp) ex = '{8'h88, tag, cmd[15:8], cmd[7:0], st};
    else ex = '{8'h80, 0, 0, 0, 0, ip[31:24], ip[23:16], ip[15:8], ip[7:0], mg, 0};
    for (i = 0; i < n; i++) begin
      pq.push_back(8'(i * 7 + 1));
      ex.push_back(8'(i * 7 + 1));
    end
    sum = 0;
    foreach (ex[j]) sum += ex[j];
    ex.push_back(8'hff - sum);
    len = ex.size() - 1;
    ex.push_front(len[7:0]);
    ex.push_front(len[15:8]);
    ex.push_front(8'h7e);
    pl_len = 11'(n);
    @(negedge clk);
    i = 0;
    while (req_ready !== 1'b1 && i < 100) begin @(negedge clk); i++; end
    check(8'(req_ready), 8'h01);
    rx_req = !rsp;
    rsp_req = rsp;
    @(negedge clk);
    rx_req = 0;
    rsp_req = 0;
    i = 0;
    while (host_model_i.q.size() < ex.size() && i < 5000) begin @(negedge clk); i++; end
    check(8'(host_model_i.q.size()), 8'(ex.size()));
    foreach (ex[j]) check(host_model_i.q[j], ex[j]);
    host_model_i.q.delete();
  endtask
  task rx_test;
    ip = 32'hc0a80067;
    mg = 8'h2e;
    run(0, 0);
    run(0, 1392);
  endtask
  // Back-to-back answers, every status code
  task rsp_write_test;
    for (int k = 0; k < 4; k++) begin
      tag = 8'(k + 1);
      cmd = 16'h5a59;
      st = 8'(k);
      run(1, 0);
    end
  endtask
  task rsp_read_test;
    tag = 8'h09;
    st = 8'h00;
    run(1, 3);
  endtask
  task complete_run;
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    complete_run;
  end
  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1;
    rx_test;
    rsp_write_test;
    rsp_read_test;
    complete_run;
  end
endmodule
